/* slx_core_model.sv */
// Stand-in for the core fetch and decode pipeline.
// Assumes the slice reports its quarter-cycle on q_phase.
`timescale 1ns/1ps
module slx_core_model
    import slx_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic [1:0]  q_phase,
    input  wire logic        osc_halted,
    output logic             instr_valid,
    output logic [15:0]      instr_word
);
    // ****************************************************************
    // Issue
    // ****************************************************************
    initial begin
        instr_valid = 1'b0;
        instr_word  = 16'h5A5A;
    end

    // Presents one word in a Q1 slot while awake; the word is inverted
    // after the slot so a late reader sees garbage, not the old word
    task automatic issue(input logic [15:0] word, output bit ok);
        ok = 1'b0;
        for (int i = 0; i < 16 && !ok; i++) begin
            @(negedge mclk);
            if (q_phase === SLX_Q1 && osc_halted === 1'b0) begin
                instr_valid = 1'b1;
                instr_word  = word;
                ok          = 1'b1;
            end
        end
        @(negedge mclk);
        instr_valid = 1'b0;
        instr_word  = ~word;
    endtask
endmodule

/* slx_exec.sv */
// Execution slice for power-down, literal-minus-accumulator and fill-ones.
// Assumes the core presents instr_word with instr_valid in phase Q1 and
// that wake inputs are already on mclk (no synchroniser here).
`timescale 1ns/1ps
module slx_exec
    import slx_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                resetn,
    input  wire logic                instr_valid,
    input  wire logic [15:0]         instr_word,
    input  wire logic                acc_load_en,
    input  wire logic [7:0]          acc_load_data,
    input  wire logic                wake_req,
    input  wire logic                wake_by_watchdog,
    output logic [1:0]               q_phase,
    output logic [7:0]               working_accumulator,
    output slx_alu_flags_type        alu_flags,
    output slx_power_flags_type      power_flags,
    output slx_file_write_type       file_write,
    output logic                     watchdog_clear,
    output logic                     osc_halted
);

    // ****************************************************************
    // Instruction register and decode
    // ****************************************************************
    logic [15:0]          ir;
    logic                 ir_valid;
    slx_power_state_type  pstate;

    wire logic take      = instr_valid && (q_phase == SLX_Q1)
                           && (pstate == SLX_RUN);
    wire logic exec_now  = ir_valid && (q_phase == SLX_Q4);
    wire logic is_pd     = (ir == SLX_OP_POWERDOWN);
    wire logic is_litsub = (ir[15:8] == SLX_OP_LITSUB_HI);
    wire logic is_fill   = (ir[15:9] == SLX_OP_FILL_HI);
    wire logic fill_acc  = is_fill && !ir[SLX_FILL_SEL_BIT];
    wire logic [7:0] lit = ir[7:0];

    // ****************************************************************
    // Subtractor: literal plus inverted accumulator plus one
    // ****************************************************************
    wire logic [8:0] diff  = {1'b0, lit} + {1'b0, ~working_accumulator}
                             + 9'h001;
    wire logic [4:0] ndiff = {1'b0, lit[3:0]}
                             + {1'b0, ~working_accumulator[3:0]} + 5'h01;
    wire logic [7:0] res   = diff[7:0];
    // Overflow when operand signs differ and the result sign leaves k
    wire logic       ovf   = (lit[7] != working_accumulator[7])
                             && (res[7] != lit[7]);

    // Phase counter; frozen at Q1 while the oscillator is stopped
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            q_phase <= SLX_Q1;
        end else if (pstate == SLX_ASLEEP) begin
            q_phase <= SLX_Q1;
        end else begin
            q_phase <= q_phase + 2'h1;
        end
    end

    // Latch the word in Q1, retire it after Q4
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ir       <= 16'h0000;
            ir_valid <= 1'b0;
        end else if (take) begin
            ir       <= instr_word;
            ir_valid <= 1'b1;
        end else if (exec_now) begin
            ir_valid <= 1'b0;
        end
    end

    // ****************************************************************
    // Accumulator; an executing op wins over a core load in the same cycle
    // ****************************************************************
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            working_accumulator <= SLX_ACC_RESET;
        end else if (exec_now && is_litsub) begin
            working_accumulator <= res;
        end else if (exec_now && fill_acc) begin
            working_accumulator <= SLX_ALL_ONES;
        end else if (acc_load_en) begin
            working_accumulator <= acc_load_data;
        end
    end

    // Arithmetic flags, only the subtract touches them
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            alu_flags <= '0;
        end else if (exec_now && is_litsub) begin
            alu_flags.overflow_flag    <= ovf;
            alu_flags.carry            <= diff[8];
            alu_flags.digit_carry_flag <= ndiff[4];
            alu_flags.zero             <= (res == 8'h00);
        end
    end

    // File write strobe, one cycle, for fill-ones
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            file_write <= '0;
        end else begin
            file_write.en   <= exec_now && is_fill;
            file_write.addr <= lit;
            file_write.data <= SLX_ALL_ONES;
        end
    end

    // ****************************************************************
    // Power-down: flags, watchdog clear, oscillator stop and wake
    // ****************************************************************
    wire logic pd_exec  = exec_now && is_pd;
    wire logic wdt_wake = (pstate == SLX_ASLEEP) && wake_req
                          && wake_by_watchdog;

    // Sleep state and oscillator stop; a wake while running is ignored
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pstate         <= SLX_RUN;
            osc_halted     <= 1'b0;
            watchdog_clear <= 1'b0;
        end else begin
            watchdog_clear <= pd_exec;
            unique case (pstate)
                SLX_RUN: begin
                    // Stop happens on the Q4 edge of the sleep cycle
                    if (pd_exec) begin
                        pstate     <= SLX_ASLEEP;
                        osc_halted <= 1'b1;
                    end
                end
                SLX_ASLEEP: begin
                    if (wake_req) begin
                        pstate     <= SLX_RUN;
                        osc_halted <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Status flags in a process of their own, so that sleep and a
    // watchdog wake stay the only writers; the two never coincide
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            power_flags.timeout_status_flag   <= SLX_TO_RESET;
            power_flags.powerdown_status_flag <= SLX_PD_RESET;
        end else if (pd_exec) begin
            power_flags.timeout_status_flag   <= 1'b1;
            power_flags.powerdown_status_flag <= 1'b0;
        end else if (wdt_wake) begin
            power_flags.timeout_status_flag <= 1'b0;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_take_pd;
        take && (instr_word == SLX_OP_POWERDOWN);
    endsequence

    sequence s_take_sub;
        take && (instr_word[15:8] == SLX_OP_LITSUB_HI);
    endsequence

    a_pd_flags_set: assert property (
        @(posedge mclk) disable iff (!resetn)
        s_take_pd |-> ##4 (power_flags.timeout_status_flag
                           && !power_flags.powerdown_status_flag))
        else $error("power-down flags wrong after sleep");

    a_pd_wdt_clear: assert property (
        @(posedge mclk) disable iff (!resetn)
        s_take_pd |-> ##4 watchdog_clear ##1 !watchdog_clear)
        else $error("watchdog clear not one pulse after sleep");

    a_pd_osc_stop: assert property (
        @(posedge mclk) disable iff (!resetn)
        s_take_pd |-> !osc_halted [*4] ##1 osc_halted)
        else $error("oscillator not stopped at Q4");

    a_wake_wdt_to: assert property (
        @(posedge mclk) disable iff (!resetn)
        (osc_halted && wake_req && wake_by_watchdog)
        |=> (!osc_halted && !power_flags.timeout_status_flag))
        else $error("watchdog wake did not clear time-out");

    a_pd_decode: assert property (
        @(posedge mclk) disable iff (!resetn)
        (take && (instr_word != SLX_OP_POWERDOWN)) |-> ##4 !watchdog_clear)
        else $error("non power-down word cleared watchdog");

    // The literal is taken back to the issue edge and the accumulator to
    // the execute edge, so a core load in between is honoured
    a_sub_result: assert property (
        @(posedge mclk) disable iff (!resetn)
        s_take_sub |-> ##4 (working_accumulator
            == 8'($past(instr_word[7:0], 4)
                  - $past(working_accumulator, 1))))
        else $error("literal subtract result wrong");

    a_sub_carry: assert property (
        @(posedge mclk) disable iff (!resetn)
        s_take_sub |-> ##4 (alu_flags.carry
            == ($past(instr_word[7:0], 4)
                >= $past(working_accumulator, 1))))
        else $error("carry is not not-borrow");

    a_sub_zero: assert property (
        @(posedge mclk) disable iff (!resetn)
        s_take_sub |-> ##4 (alu_flags.zero
            == ($past(instr_word[7:0], 4)
                == $past(working_accumulator, 1))))
        else $error("zero flag wrong after subtract");

    a_sub_digit: assert property (
        @(posedge mclk) disable iff (!resetn)
        s_take_sub |-> ##4 (alu_flags.digit_carry_flag
            == ($past(instr_word[3:0], 4)
                >= $past(working_accumulator[3:0], 1))))
        else $error("digit carry is not nibble not-borrow");

    a_fill_write: assert property (
        @(posedge mclk) disable iff (!resetn)
        (take && (instr_word[15:9] == SLX_OP_FILL_HI))
        |-> ##4 (file_write.en && file_write.data == SLX_ALL_ONES
                 && file_write.addr == $past(instr_word[7:0], 4)
                 && $stable(alu_flags)))
        else $error("fill-ones write missing or flags moved");

    a_fill_acc: assert property (
        @(posedge mclk) disable iff (!resetn)
        (take && (instr_word[15:8] == {SLX_OP_FILL_HI, 1'b0}))
        |-> ##4 (working_accumulator == SLX_ALL_ONES))
        else $error("fill-ones with select clear missed accumulator");

    a_sub_decode: assert property (
        @(posedge mclk) disable iff (!resetn)
        (take && (instr_word[15:8] != SLX_OP_LITSUB_HI)
         && (instr_word[15:9] != SLX_OP_FILL_HI) && !acc_load_en)
        |-> ##4 ($stable(alu_flags)))
        else $error("flags moved on foreign opcode");

endmodule

/* slx_exec_tb.sv */
// Self-checking bench for the power-down, subtract and fill slice.
// Assumes the core model file is compiled before this one.
`timescale 1ns/1ps
module slx_exec_tb;
    import slx_pkg::*;
    logic                mclk, resetn, instr_valid, acc_load_en;
    logic                wake_req, wake_by_watchdog;
    logic                watchdog_clear, osc_halted;
    logic [15:0]         instr_word;
    logic [7:0]          acc_load_data, working_accumulator;
    logic [1:0]          q_phase;
    slx_alu_flags_type   alu_flags, exp_flags;
    slx_power_flags_type power_flags;
    slx_file_write_type  file_write;
    int                  bad_count = 0;
    int                  cmp_count = 0;

    slx_exec dut_u (.mclk(mclk), .resetn(resetn),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .acc_load_en(acc_load_en), .acc_load_data(acc_load_data),
        .wake_req(wake_req), .wake_by_watchdog(wake_by_watchdog),
        .q_phase(q_phase), .working_accumulator(working_accumulator),
        .alu_flags(alu_flags), .power_flags(power_flags),
        .file_write(file_write), .watchdog_clear(watchdog_clear),
        .osc_halted(osc_halted));
    slx_core_model core_u (.mclk(mclk), .q_phase(q_phase),
        .osc_halted(osc_halted), .instr_valid(instr_valid),
        .instr_word(instr_word));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic summarize();
        if (bad_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [16:0] exp,
                       input logic [16:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", name, exp, got);
        end
    endtask

    // Issues a word, then lands on the cycle after the Q4 edge
    task automatic run(input logic [15:0] word);
        bit ok;
        core_u.issue(word, ok);
        if (!ok) begin
            bad_count++;
            summarize();
        end
        repeat (3) @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic load_acc(input logic [7:0] v);
        @(negedge mclk);
        acc_load_en   = 1'b1;
        acc_load_data = v;
        @(negedge mclk);
        acc_load_en   = 1'b0;
        acc_load_data = ~v;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Pairs are literal then accumulator: sign, zero and nibble cases
    task automatic t_litsub();
        logic [7:0]  k, w, r;
        logic [15:0] tbl [6] = '{16'h0201, 16'h0202, 16'h0203,
                                 16'h8001, 16'h1F2E, 16'h7FFF};
        for (int i = 0; i < 6; i++) begin
            k = tbl[i][15:8];
            w = tbl[i][7:0];
            r = k - w;
            exp_flags.carry = k >= w;
            exp_flags.digit_carry_flag = k[3:0] >= w[3:0];
            exp_flags.zero = r == 8'h00;
            exp_flags.overflow_flag = k[7] != w[7] && r[7] != k[7];
            load_acc(w);
            run({SLX_OP_LITSUB_HI, k});
            chk("litsub acc", r, working_accumulator);
            chk("litsub flags", exp_flags, alu_flags);
        end
    endtask

    // Select bit one first, so the accumulator change is visible
    task automatic t_fill();
        logic [7:0] a, e;
        load_acc(8'h05);
        for (int s = 1; s >= 0; s--) begin
            a = 8'h3C + 8'(s);
            e = (s == 1) ? 8'h05 : SLX_ALL_ONES;
            run({SLX_OP_FILL_HI, s[0], a});
            chk("fill write", {1'b1, a, 8'hFF}, file_write);
            chk("fill acc", e, working_accumulator);
            chk("fill flags", exp_flags, alu_flags);
            @(negedge mclk);
            chk("fill pulse", 1'b0, file_write.en);
        end
    endtask

    // Near-miss word, then sleep, then a wake from the given source
    task automatic t_sleep(input logic by_wdt);
        run(16'h0002);
        chk("near miss", 2'b00, {watchdog_clear, osc_halted});
        run(SLX_OP_POWERDOWN);
        chk("wdt clear", 1'b1, watchdog_clear);
        chk("halt", 1'b1, osc_halted);
        chk("power flags", 2'b10, power_flags);
        chk("alu kept", exp_flags, alu_flags);
        @(negedge mclk);
        chk("asleep", 2'b01, {watchdog_clear, osc_halted});
        chk("asleep phase", SLX_Q1, q_phase);
        wake_req         = 1'b1;
        wake_by_watchdog = by_wdt;
        @(negedge mclk);
        wake_req = 1'b0;
        chk("woken", 1'b0, osc_halted);
        chk("wake flags", {~by_wdt, 1'b0}, power_flags);
    endtask

    // Holds reset for twelve cycles, checks every output except file_write addr and data at rest, and
    // releases on a falling edge; usable at start and in mid-run
    task automatic t_reset();
        resetn = 1'b0;
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        chk("reset", {SLX_ACC_RESET, 4'h0, SLX_TO_RESET, SLX_PD_RESET,
            3'h0}, {working_accumulator, alu_flags, power_flags,
            osc_halted, watchdog_clear, file_write.en});
        chk("reset phase", SLX_Q1, q_phase);
        resetn    = 1'b1;
        exp_flags = '0;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        resetn           = 1'b0;
        acc_load_en      = 1'b0;
        acc_load_data    = 8'h00;
        wake_req         = 1'b0;
        wake_by_watchdog = 1'b0;
        t_reset();
        t_litsub();
        t_fill();
        t_sleep(1'b1);
        t_reset();
        t_sleep(1'b0);
        summarize();
    end
endmodule

/* slx_pkg.sv */
// Constants, encodings and carrier types for the power-down, literal
// subtract and fill-ones execution slice.
// Assumes a core pipeline on the same clock that issues one instruction
// word per four-phase instruction cycle.
package slx_pkg;

    // ****************************************************************
    // Encodings
    // ****************************************************************
    localparam logic [15:0] SLX_OP_POWERDOWN = 16'h0003;
    localparam logic [7:0]  SLX_OP_LITSUB_HI = 8'hB2;
    localparam logic [6:0]  SLX_OP_FILL_HI   = 7'h15;
    localparam int          SLX_FILL_SEL_BIT = 8;
    localparam logic [7:0]  SLX_ALL_ONES     = 8'hFF;

    // ****************************************************************
    // Quarter-cycle phases and reset values
    // ****************************************************************
    localparam logic [1:0]  SLX_Q1           = 2'h0;
    localparam logic [1:0]  SLX_Q4           = 2'h3;
    localparam logic [7:0]  SLX_ACC_RESET    = 8'h00;
    localparam logic        SLX_TO_RESET     = 1'b1;
    localparam logic        SLX_PD_RESET     = 1'b1;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic overflow_flag;
        logic zero;
        logic digit_carry_flag;
        logic carry;
    } slx_alu_flags_type;

    typedef struct packed {
        logic timeout_status_flag;
        logic powerdown_status_flag;
    } slx_power_flags_type;

    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } slx_file_write_type;

    typedef enum logic [0:0] {
        SLX_RUN,
        SLX_ASLEEP
    } slx_power_state_type;

endpackage
